// ### core/aqa_pkg.sv
// Purpose: Shared constants and types for the converter queue arbiter
// Assumes: One 125 MHz clock, registers reached over AXI4-Lite
// Notes: Offsets are byte addresses, one aligned 32-bit word each
package aqa_pkg;

  // ------------------------------------------------------------------
  // Register map and field layout
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL1 = 8'h00;
  localparam logic [7:0] ADDR_CTRL2 = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_TIMER = 8'h0C;
  localparam int MODE_LSB = 0;
  localparam int GO_BIT = 3;
  localparam int RESUME_BIT = 4;
  localparam int BQ2_LSB = 8;
  localparam int F_CF1 = 0;
  localparam int F_PF1 = 1;
  localparam int F_TOR1 = 2;
  localparam int F_CF2 = 3;
  localparam int F_PF2 = 4;
  localparam int F_TOR2 = 5;
  localparam int QS_LSB = 8;
  localparam int IDX_LSB = 16;

  // ------------------------------------------------------------------
  // Reset values and fixed codes
  // ------------------------------------------------------------------
  localparam logic [2:0] MODE_RST = 3'h0;
  localparam logic [6:0] BQ2_RST = 7'h20;
  localparam logic [15:0] PERIOD_RST = 16'h07CF;
  localparam logic [5:0] END_CHANNEL = 6'h3F;
  localparam logic [6:0] TABLE_END = 7'h40;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Queue operating modes; the timer mode serves the second queue only
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_SW_SINGLE = 3'h1;
  localparam logic [2:0] MODE_EXT_SINGLE = 3'h2;
  localparam logic [2:0] MODE_EXT_CONT = 3'h3;
  localparam logic [2:0] MODE_SW_CONT = 3'h4;
  localparam logic [2:0] MODE_TIMER = 3'h5;

  typedef enum logic [2:0] {
    QST_IDLE = 3'b000,
    QST_PAUSED = 3'b001,
    QST_ACTIVE = 3'b010,
    QST_PENDING = 3'b011,
    QST_SUSP = 3'b100
  } aqa_qst_t;

  typedef enum logic [1:0] {
    SQ_IDLE = 2'b00,
    SQ_FETCH = 2'b01,
    SQ_DECODE = 2'b10,
    SQ_CONV = 2'b11
  } aqa_seq_t;

  // Two bits per queue; suspended shares the active code
  function automatic logic [1:0] qst_code(aqa_qst_t s);
    case (s)
      QST_PAUSED: qst_code = 2'h1;
      QST_ACTIVE: qst_code = 2'h2;
      QST_SUSP: qst_code = 2'h2;
      QST_PENDING: qst_code = 2'h3;
      default: qst_code = 2'h0;
    endcase
  endfunction

endpackage

// ### core/aqa_arbiter.sv
// Purpose: Shares one converter core between two command queues
// Assumes: Command table answers cmd_channel/cmd_pause in the cycle of cmd_index
// Notes: Converter signals conv_done once per started, unaborted conversion
//
// Chosen here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps

// Behaviour
// - Idle arbiter starts a triggered queue at once
// - Second queue trigger waits while first runs
// - Extra pending second trigger sets overrun only
// - First trigger aborts and suspends second queue
// - Trigger while suspended sets overrun only
// - Suspended second queue restarts after first stops
// - Restart bit picks first or aborted command
// - Simultaneous triggers: first runs, second pends
// - Pause bit ends a subqueue
// - Each subqueue needs a fresh mode trigger
// - Single or continuous applies to whole queue
// - Subqueue runs in order, resumes after pause
// - No subqueue reruns before queue completes
// - Trigger during execution sets overrun only
// - Continuous queue restarts at first command
// - Pause finishes conversion, flags, then waits
// - First queue: external, software, loop end
// - Second queue adds the periodic timer
// - Completion flag set at queue end
// - Early trigger sets the overrun flag
// - Four-bit code shows both queue states
// - Channel 63 ends queue without conversion
module aqa_arbiter #(
  parameter int ADDR_W = 8
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic first_queue_trigger,
  input wire logic second_queue_trigger,
  output logic [5:0] cmd_index,
  input wire logic [5:0] cmd_channel,
  input wire logic cmd_pause,
  output logic conv_start,
  output logic [5:0] conv_channel,
  output logic conv_abort,
  input wire logic conv_done,
  output logic [3:0] queue_state_code
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic [2:0] mode1_reg, mode2_reg;
  logic resume_reg;
  logic [6:0] bq2_reg;
  logic [15:0] period_reg, timer_reg;
  logic timer_tick_reg;
  logic ext1_prev_reg, ext2_prev_reg;
  logic arm1_reg, arm2_reg;
  logic cf1_reg, pf1_reg, tor1_reg, cf2_reg, pf2_reg, tor2_reg;
  aqa_pkg::aqa_qst_t st1_reg, st2_reg;
  aqa_pkg::aqa_seq_t seq_reg;
  logic owner_reg;
  logic [6:0] ptr1_reg, ptr2_reg;
  logic wr_go, go1, go2, trig1, trig2;
  logic [5:0] clr;
  logic [6:0] cur_ptr, nxt_ptr;
  logic at_end, nxt_end, preempt, finish, pausing;

  // ------------------------------------------------------------------
  // AXI4-Lite slave
  // ------------------------------------------------------------------
  // Write fires once address and data are both held and no answer is out
  assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign go1 = wr_go && aw_addr_reg == aqa_pkg::ADDR_CTRL1 && wstrb_reg[0]
    && wdata_reg[aqa_pkg::GO_BIT];
  assign go2 = wr_go && aw_addr_reg == aqa_pkg::ADDR_CTRL2 && wstrb_reg[0]
    && wdata_reg[aqa_pkg::GO_BIT];
  // Write-one-to-clear of the sticky flags
  assign clr = (wr_go && aw_addr_reg == aqa_pkg::ADDR_STATUS && wstrb_reg[0])
    ? wdata_reg[5:0] : 6'h00;

  // Write channels are taken in either order and released together once the answer is taken
  always_ff @(posedge clock) begin
    if (reset) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= aqa_pkg::RESP_OKAY;
      aw_addr_reg <= '0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_reg > aqa_pkg::ADDR_TIMER || aw_addr_reg[1:0] != 2'h0)
          ? aqa_pkg::RESP_SLVERR : aqa_pkg::RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Control fields; byte lanes honoured where a field lives
  always_ff @(posedge clock) begin
    if (reset) begin
      mode1_reg <= aqa_pkg::MODE_RST;
      mode2_reg <= aqa_pkg::MODE_RST;
      resume_reg <= 1'b0;
      bq2_reg <= aqa_pkg::BQ2_RST;
      period_reg <= aqa_pkg::PERIOD_RST;
    end else if (wr_go) begin
      if (aw_addr_reg == aqa_pkg::ADDR_CTRL1 && wstrb_reg[0]) begin
        mode1_reg <= wdata_reg[aqa_pkg::MODE_LSB +: 3];
      end
      if (aw_addr_reg == aqa_pkg::ADDR_CTRL2) begin
        if (wstrb_reg[0]) begin
          mode2_reg <= wdata_reg[aqa_pkg::MODE_LSB +: 3];
          resume_reg <= wdata_reg[aqa_pkg::RESUME_BIT];
        end
        if (wstrb_reg[1]) begin
          bq2_reg <= wdata_reg[aqa_pkg::BQ2_LSB +: 7];
        end
      end
      if (aw_addr_reg == aqa_pkg::ADDR_TIMER) begin
        if (wstrb_reg[0]) begin
          period_reg[7:0] <= wdata_reg[7:0];
        end
        if (wstrb_reg[1]) begin
          period_reg[15:8] <= wdata_reg[15:8];
        end
      end
    end
  end

  // Read answer one cycle after the address is taken
  always_ff @(posedge clock) begin
    if (reset) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= aqa_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= aqa_pkg::RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      case (s_axi_araddr)
        aqa_pkg::ADDR_CTRL1: s_axi_rdata[2:0] <= mode1_reg;
        aqa_pkg::ADDR_CTRL2: s_axi_rdata <= {17'h0, bq2_reg, 3'h0, resume_reg, 1'b0, mode2_reg};
        aqa_pkg::ADDR_STATUS: s_axi_rdata <= {10'h000, cmd_index, 4'h0, queue_state_code,
          2'h0, tor2_reg, pf2_reg, cf2_reg, tor1_reg, pf1_reg, cf1_reg};
        aqa_pkg::ADDR_TIMER: s_axi_rdata[15:0] <= period_reg;
        default: s_axi_rresp <= aqa_pkg::RESP_SLVERR;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // Trigger sources
  // ------------------------------------------------------------------
  // Periodic timer runs only in timer mode so the first period is whole
  always_ff @(posedge clock) begin
    if (reset) begin
      timer_reg <= aqa_pkg::PERIOD_RST;
      timer_tick_reg <= 1'b0;
      ext1_prev_reg <= 1'b0;
      ext2_prev_reg <= 1'b0;
    end else begin
      ext1_prev_reg <= first_queue_trigger;
      ext2_prev_reg <= second_queue_trigger;
      timer_tick_reg <= 1'b0;
      if (mode2_reg != aqa_pkg::MODE_TIMER || timer_reg == 16'h0000) begin
        timer_reg <= period_reg;
        timer_tick_reg <= mode2_reg == aqa_pkg::MODE_TIMER;
      end else begin
        timer_reg <= timer_reg - 16'h0001;
      end
    end
  end

  // Each subqueue start needs a new event of the queue's own mode
  always_comb begin
    // A go bit acts with the mode written in the same word
    trig1 = (go1 && (wdata_reg[aqa_pkg::MODE_LSB +: 3] == aqa_pkg::MODE_SW_SINGLE
      || wdata_reg[aqa_pkg::MODE_LSB +: 3] == aqa_pkg::MODE_SW_CONT))
      || (first_queue_trigger && !ext1_prev_reg
      && ((mode1_reg == aqa_pkg::MODE_EXT_SINGLE && arm1_reg)
      || mode1_reg == aqa_pkg::MODE_EXT_CONT));
    trig2 = (go2 && (wdata_reg[aqa_pkg::MODE_LSB +: 3] == aqa_pkg::MODE_SW_SINGLE
      || wdata_reg[aqa_pkg::MODE_LSB +: 3] == aqa_pkg::MODE_SW_CONT))
      || (second_queue_trigger && !ext2_prev_reg
      && ((mode2_reg == aqa_pkg::MODE_EXT_SINGLE && arm2_reg)
      || mode2_reg == aqa_pkg::MODE_EXT_CONT))
      || timer_tick_reg;
  end

  // ------------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------------
  // Queue one spans up to the second queue's start, queue two to the table end
  always_comb begin
    cur_ptr = owner_reg ? ptr2_reg : ptr1_reg;
    nxt_ptr = cur_ptr + 7'h01;
    at_end = owner_reg ? cur_ptr >= aqa_pkg::TABLE_END
      : (cur_ptr >= bq2_reg || cur_ptr >= aqa_pkg::TABLE_END);
    nxt_end = owner_reg ? nxt_ptr >= aqa_pkg::TABLE_END
      : (nxt_ptr >= bq2_reg || nxt_ptr >= aqa_pkg::TABLE_END);
    preempt = owner_reg && seq_reg != aqa_pkg::SQ_IDLE
      && st1_reg == aqa_pkg::QST_PENDING;
    finish = (seq_reg == aqa_pkg::SQ_FETCH && at_end)
      || (seq_reg == aqa_pkg::SQ_DECODE && cmd_channel == aqa_pkg::END_CHANNEL)
      || (seq_reg == aqa_pkg::SQ_CONV && conv_done && nxt_end);
    pausing = seq_reg == aqa_pkg::SQ_CONV && conv_done && cmd_pause;
  end

  // Flag clears come first so a same-cycle set wins
  always_ff @(posedge clock) begin
    if (reset) begin
      seq_reg <= aqa_pkg::SQ_IDLE;
      owner_reg <= 1'b0;
      st1_reg <= aqa_pkg::QST_IDLE;
      st2_reg <= aqa_pkg::QST_IDLE;
      ptr1_reg <= 7'h00;
      ptr2_reg <= aqa_pkg::BQ2_RST;
      {tor2_reg, pf2_reg, cf2_reg, tor1_reg, pf1_reg, cf1_reg} <= 6'h00;
      arm1_reg <= 1'b0;
      arm2_reg <= 1'b0;
      cmd_index <= 6'h00;
      conv_start <= 1'b0;
      conv_abort <= 1'b0;
      conv_channel <= 6'h00;
    end else begin
      conv_start <= 1'b0;
      conv_abort <= 1'b0;
      {tor2_reg, pf2_reg, cf2_reg, tor1_reg, pf1_reg, cf1_reg} <=
        {tor2_reg, pf2_reg, cf2_reg, tor1_reg, pf1_reg, cf1_reg} & ~clr;
      if (trig1) begin
        if (st1_reg == aqa_pkg::QST_ACTIVE || st1_reg == aqa_pkg::QST_PENDING) begin
          tor1_reg <= 1'b1;
        end else begin
          st1_reg <= aqa_pkg::QST_PENDING;
        end
      end
      if (trig2) begin
        if (st2_reg == aqa_pkg::QST_IDLE || st2_reg == aqa_pkg::QST_PAUSED) begin
          st2_reg <= aqa_pkg::QST_PENDING;
        end else begin
          tor2_reg <= 1'b1;
        end
      end
      if (preempt) begin
        // Abort, not finish, keeps first-queue latency fixed
        conv_abort <= seq_reg == aqa_pkg::SQ_CONV;
        st2_reg <= aqa_pkg::QST_SUSP;
        st1_reg <= aqa_pkg::QST_ACTIVE;
        owner_reg <= 1'b0;
        seq_reg <= aqa_pkg::SQ_FETCH;
      end else if (finish) begin
        // Loop end re-triggers only the software continuous mode
        seq_reg <= aqa_pkg::SQ_IDLE;
        if (owner_reg) begin
          cf2_reg <= 1'b1;
          if (pausing) begin
            pf2_reg <= 1'b1;
          end
          ptr2_reg <= bq2_reg;
          st2_reg <= mode2_reg == aqa_pkg::MODE_SW_CONT
            ? aqa_pkg::QST_PENDING : aqa_pkg::QST_IDLE;
          arm2_reg <= 1'b0;
        end else begin
          cf1_reg <= 1'b1;
          if (pausing) begin
            pf1_reg <= 1'b1;
          end
          ptr1_reg <= 7'h00;
          st1_reg <= mode1_reg == aqa_pkg::MODE_SW_CONT
            ? aqa_pkg::QST_PENDING : aqa_pkg::QST_IDLE;
          arm1_reg <= 1'b0;
        end
      end else if (pausing) begin
        seq_reg <= aqa_pkg::SQ_IDLE;
        if (owner_reg) begin
          pf2_reg <= 1'b1;
          ptr2_reg <= nxt_ptr;
          st2_reg <= aqa_pkg::QST_PAUSED;
        end else begin
          pf1_reg <= 1'b1;
          ptr1_reg <= nxt_ptr;
          st1_reg <= aqa_pkg::QST_PAUSED;
        end
      end else begin
        case (seq_reg)
          aqa_pkg::SQ_IDLE: begin
            if (st1_reg == aqa_pkg::QST_PENDING) begin
              owner_reg <= 1'b0;
              st1_reg <= aqa_pkg::QST_ACTIVE;
              seq_reg <= aqa_pkg::SQ_FETCH;
            end else if (st2_reg == aqa_pkg::QST_PENDING || st2_reg == aqa_pkg::QST_SUSP) begin
              owner_reg <= 1'b1;
              st2_reg <= aqa_pkg::QST_ACTIVE;
              seq_reg <= aqa_pkg::SQ_FETCH;
              if (st2_reg == aqa_pkg::QST_SUSP && !resume_reg) begin
                ptr2_reg <= bq2_reg;
              end
            end
          end
          aqa_pkg::SQ_FETCH: begin
            cmd_index <= cur_ptr[5:0];
            seq_reg <= aqa_pkg::SQ_DECODE;
          end
          aqa_pkg::SQ_DECODE: begin
            conv_start <= 1'b1;
            conv_channel <= cmd_channel;
            seq_reg <= aqa_pkg::SQ_CONV;
          end
          aqa_pkg::SQ_CONV: begin
            if (conv_done) begin
              seq_reg <= aqa_pkg::SQ_FETCH;
              if (owner_reg) begin
                ptr2_reg <= nxt_ptr;
              end else begin
                ptr1_reg <= nxt_ptr;
              end
            end
          end
          default: seq_reg <= aqa_pkg::SQ_IDLE;
        endcase
      end
      if (go1) begin
        arm1_reg <= 1'b1;
      end
      if (go2) begin
        arm2_reg <= 1'b1;
      end
    end
  end

  // Status code lags the queue states by one cycle
  always_ff @(posedge clock) begin
    if (reset) begin
      queue_state_code <= 4'h0;
    end else begin
      queue_state_code <= {aqa_pkg::qst_code(st1_reg), aqa_pkg::qst_code(st2_reg)};
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  a_idle_start: assert property (
    seq_reg == aqa_pkg::SQ_IDLE && st1_reg == aqa_pkg::QST_PENDING
    |=> st1_reg == aqa_pkg::QST_ACTIVE ##1 seq_reg == aqa_pkg::SQ_DECODE)
    else $error("first queue did not start");
  a_second_held: assert property (
    st1_reg == aqa_pkg::QST_ACTIVE && trig2 && st2_reg == aqa_pkg::QST_IDLE
    |=> st2_reg == aqa_pkg::QST_PENDING)
    else $error("second trigger not held");
  a_pending_overrun: assert property (
    trig2 && st2_reg == aqa_pkg::QST_PENDING && !clr[aqa_pkg::F_TOR2] |=> tor2_reg)
    else $error("overrun missed while pending");
  a_preempt_abort: assert property (
    preempt && seq_reg == aqa_pkg::SQ_CONV
    |=> conv_abort && st2_reg == aqa_pkg::QST_SUSP && !owner_reg)
    else $error("second queue not aborted");
  a_susp_overrun: assert property (
    trig2 && st2_reg == aqa_pkg::QST_SUSP |=> tor2_reg)
    else $error("overrun missed while suspended");
  a_restart_first: assert property (
    seq_reg == aqa_pkg::SQ_IDLE && st1_reg != aqa_pkg::QST_PENDING
    && st2_reg == aqa_pkg::QST_SUSP && !resume_reg |=> ptr2_reg == $past(bq2_reg))
    else $error("restart not at first command");
  a_restart_same: assert property (
    seq_reg == aqa_pkg::SQ_IDLE && st1_reg != aqa_pkg::QST_PENDING
    && st2_reg == aqa_pkg::QST_SUSP && resume_reg |=> $stable(ptr2_reg))
    else $error("restart not at aborted command");
  a_both_triggers: assert property (
    trig1 && trig2 && seq_reg == aqa_pkg::SQ_IDLE
    && st1_reg == aqa_pkg::QST_IDLE && st2_reg == aqa_pkg::QST_IDLE
    |=> ##1 st1_reg == aqa_pkg::QST_ACTIVE && st2_reg == aqa_pkg::QST_PENDING)
    else $error("simultaneous triggers misordered");
  a_pause_stop: assert property (
    pausing && !finish && !preempt && !owner_reg
    |=> st1_reg == aqa_pkg::QST_PAUSED && pf1_reg && seq_reg == aqa_pkg::SQ_IDLE)
    else $error("pause not entered");
  a_step_next: assert property (
    seq_reg == aqa_pkg::SQ_CONV && conv_done && !pausing && !finish && !preempt
    |=> seq_reg == aqa_pkg::SQ_FETCH && cur_ptr == $past(nxt_ptr))
    else $error("command order broken");
  a_end_noconv: assert property (
    seq_reg == aqa_pkg::SQ_DECODE && cmd_channel == aqa_pkg::END_CHANNEL && !preempt
    |=> !conv_start && seq_reg == aqa_pkg::SQ_IDLE && (cf1_reg || cf2_reg))
    else $error("end marker converted");

  c_preempt: cover property (preempt && seq_reg == aqa_pkg::SQ_CONV);
  c_pause: cover property (pausing && !finish);
  c_both: cover property (trig1 && trig2);
  c_overrun: cover property (trig2 && st2_reg == aqa_pkg::QST_SUSP);

endmodule

// ### sim/aqa_conv_model.sv
// Purpose: Converter core and command table facing the arbiter
// Assumes: One conversion at a time, started by a one-cycle pulse
// Notes: Latency set by slow; an abort drops the conversion silently
`timescale 1ns/100ps
module aqa_conv_model (
  input wire logic clock,
  input wire logic reset,
  input wire logic [5:0] cmd_index,
  output logic [5:0] cmd_channel,
  output logic cmd_pause,
  input wire logic conv_start,
  input wire logic conv_abort,
  input wire logic slow,
  output logic conv_done
);
  // --------------------------------
  // Table and conversion timer
  // --------------------------------
  logic [5:0] ch_tab [64];
  logic ps_tab [64];
  logic [7:0] cnt_reg;

  // Table answers in the cycle of the index
  assign cmd_channel = ch_tab[cmd_index];
  assign cmd_pause = ps_tab[cmd_index];

  // Slow mode leaves room to preempt mid-conversion
  always_ff @(posedge clock) begin
    if (reset || conv_abort) begin
      cnt_reg <= 8'h00;
    end else if (conv_start) begin
      cnt_reg <= slow ? 8'h28 : 8'h03;
    end else if (cnt_reg != 8'h00) begin
      cnt_reg <= cnt_reg - 8'h01;
    end
  end

  // One done pulse per unaborted start
  always_ff @(posedge clock) begin
    conv_done <= !reset && !conv_abort && (cnt_reg == 8'h01);
  end
endmodule

// ### sim/tb_adc_queue_arbiter.sv
// Purpose: Self-checking bench for the converter queue arbiter
// Assumes: Converter model answers every unaborted start
// Notes: Driver queues expected channels, monitor pops them per start
`timescale 1ns/100ps
module tb_adc_queue_arbiter;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic first_queue_trigger = 1'b0;
  logic second_queue_trigger = 1'b0;
  logic conv_slow = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic cmd_pause, conv_start, conv_abort, conv_done;
  logic [1:0] s_axi_bresp, s_axi_rresp, wr_resp, rd_resp;
  logic [31:0] s_axi_rdata, rd_val;
  logic [5:0] cmd_index, cmd_channel, conv_channel;
  logic [3:0] queue_state_code;
  logic [5:0] exp_q [$];
  logic [5:0] q1ch [3];
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;
  int starts = 0;
  int aborts = 0;
  int s0, a0;

  always #4 clock = ~clock;

  aqa_arbiter dut (.clock, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .first_queue_trigger,
    .second_queue_trigger, .cmd_index, .cmd_channel, .cmd_pause, .conv_start,
    .conv_channel, .conv_abort, .conv_done, .queue_state_code);

  aqa_conv_model m (.clock, .reset, .cmd_index, .cmd_channel, .cmd_pause,
    .conv_start, .conv_abort, .slow(conv_slow), .conv_done);

  // --------------------------------
  // Checking and closing
  // --------------------------------
  task check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task give_verdict;
    $display("comparisons=%0d mismatches=%0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Every start must match the oldest queued channel; a hang ends the run
  always @(posedge clock) begin
    cyc++;
    if (conv_start === 1'b1) begin
      starts++;
      if (exp_q.size() == 0) check(32'(conv_channel), 32'hFFFF);
      else check(32'(conv_channel), 32'(exp_q.pop_front()));
    end
    if (conv_abort === 1'b1) aborts++;
    if (cyc == 30000) begin
      fails++;
      give_verdict();
    end
  end

  // --------------------------------
  // Bus and stimulus helpers
  // --------------------------------
  // Each channel drops its valid only at the edge that takes it
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      wr_resp = s_axi_bresp;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask

  task rd(input logic [7:0] a);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      rd_val = s_axi_rdata;
      rd_resp = s_axi_rresp;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] e);
    rd(a);
    check(rd_val & msk, e);
  endtask

  // Read the six flags, then clear them all
  task flags(input logic [31:0] e);
    rdc(aqa_pkg::ADDR_STATUS, 32'h3F, e);
    wr(aqa_pkg::ADDR_STATUS, 32'h3F);
  endtask

  task wait_code(input logic [3:0] c);
    do @(posedge clock); while (!(exp_q.size() == 0 && queue_state_code === c));
  endtask

  task wait_starts(input int n);
    do @(posedge clock); while (starts < n);
  endtask

  task push_q1;
    foreach (q1ch[i]) exp_q.push_back(q1ch[i]);
  endtask

  task push_q2(input int from);
    for (int i = from; i < 3; i++) exp_q.push_back(6'(10 + i));
  endtask

  task pulse(input logic p1, input logic p2);
    @(posedge clock);
    first_queue_trigger <= p1;
    second_queue_trigger <= p2;
    @(posedge clock);
    first_queue_trigger <= 1'b0;
    second_queue_trigger <= 1'b0;
    repeat (3) @(posedge clock);
  endtask

  // --------------------------------
  // Main sequence
  // --------------------------------
  initial begin
    void'($urandom(32'hDF40));
    for (int i = 0; i < 64; i++) begin
      m.ch_tab[i] = 6'h3F;
      m.ps_tab[i] = 1'b0;
    end
    for (int i = 0; i < 3; i++) begin
      q1ch[i] = 6'($urandom % 63);
      m.ch_tab[i] = q1ch[i];
      m.ch_tab[32 + i] = 6'(10 + i);
    end
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    rdc(aqa_pkg::ADDR_CTRL2, 32'h7F1F, 32'h2000);
    rdc(aqa_pkg::ADDR_TIMER, 32'hFFFF, 32'h07CF);
    rd(8'h10);
    check(32'(rd_resp), 32'(aqa_pkg::RESP_SLVERR));
    wr(8'h10, 32'h0);
    check(32'(wr_resp), 32'(aqa_pkg::RESP_SLVERR));
    $display("test registers done");
    // Software single run, extra go while converting
    conv_slow <= 1'b1;
    push_q1();
    wr(aqa_pkg::ADDR_CTRL1, 32'h9);
    wait_starts(1);
    wr(aqa_pkg::ADDR_CTRL1, 32'h9);
    wait_code(4'h0);
    flags(32'h05);
    $display("test single run done");
    // Pause after the second word needs a fresh go
    m.ps_tab[1] <= 1'b1;
    exp_q.push_back(q1ch[0]);
    exp_q.push_back(q1ch[1]);
    wr(aqa_pkg::ADDR_CTRL1, 32'h9);
    wait_code(4'h4);
    flags(32'h02);
    exp_q.push_back(q1ch[2]);
    wr(aqa_pkg::ADDR_CTRL1, 32'h9);
    wait_code(4'h0);
    flags(32'h01);
    m.ps_tab[1] <= 1'b0;
    $display("test pause done");
    // Second queue held behind the first, twice triggered
    push_q1();
    push_q2(0);
    s0 = starts;
    wr(aqa_pkg::ADDR_CTRL1, 32'h9);
    wait_starts(s0 + 1);
    wr(aqa_pkg::ADDR_CTRL2, 32'h2009);
    rdc(aqa_pkg::ADDR_STATUS, 32'hF00, 32'hB00);
    wr(aqa_pkg::ADDR_CTRL2, 32'h2009);
    wait_code(4'h0);
    flags(32'h29);
    $display("test pending done");
    // First queue preempts the second, both restart points
    for (int r = 0; r < 2; r++) begin
      wr(aqa_pkg::ADDR_CTRL1, 32'h3);
      exp_q.push_back(6'h0A);
      exp_q.push_back(6'h0B);
      s0 = starts;
      a0 = aborts;
      wr(aqa_pkg::ADDR_CTRL2, 32'h2009 | 32'(r << 4));
      wait_starts(s0 + 2);
      push_q1();
      push_q2(r);
      pulse(1'b1, 1'b0);
      rdc(aqa_pkg::ADDR_STATUS, 32'hF00, 32'hA00);
      wr(aqa_pkg::ADDR_CTRL2, 32'h2009 | 32'(r << 4));
      wait_code(4'h0);
      check(32'(aborts - a0), 32'h1);
      flags(32'h29);
    end
    $display("test preemption done");
    // Both pins rise together
    conv_slow <= 1'b0;
    wr(aqa_pkg::ADDR_CTRL2, 32'h2003);
    push_q1();
    push_q2(0);
    pulse(1'b1, 1'b1);
    wait_code(4'h0);
    flags(32'h09);
    wr(aqa_pkg::ADDR_CTRL1, 32'h0);
    wr(aqa_pkg::ADDR_CTRL2, 32'h2000);
    $display("test simultaneous done");
    // Timer ticks the second queue once; mode is dropped before the next tick
    wr(aqa_pkg::ADDR_TIMER, 32'hC7);
    push_q2(0);
    wr(aqa_pkg::ADDR_CTRL2, 32'h2005);
    wait_code(4'h0);
    wr(aqa_pkg::ADDR_CTRL2, 32'h2000);
    flags(32'h08);
    $display("test timer done");
    give_verdict();
  end
endmodule
